// >>> rfcbs_pkg.sv
/*
   Constants for the channel and band select register group: register
   offsets, field positions, reset values, band codes and carrier figures.
   Assumes an 8-bit register space reached through a 6-bit address.
*/
package rfcbs_pkg;

   // Register space geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int FREQ_W = 14;

   // Register offsets
   localparam logic [5:0] STD_CHANNEL_CCA_OFF = 6'h08;
   localparam logic [5:0] ALT_CHANNEL_NUMBER_OFF = 6'h13;
   localparam logic [5:0] BAND_SELECT_OFF = 6'h14;
   localparam logic [5:0] CF_CALIBRATION_CTRL_OFF = 6'h1A;

   // Reset values
   localparam logic [7:0] STD_CHANNEL_CCA_RST = 8'h00;
   localparam logic [7:0] ALT_CHANNEL_NUMBER_RST = 8'h00;
   localparam logic [7:0] BAND_SELECT_RST = 8'h00;
   localparam logic [7:0] CF_CALIBRATION_CTRL_RST = 8'h48;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Field layout
   localparam int STD_CHANNEL_MSB = 4;
   localparam int BAND_SEL_MSB = 2;
   localparam int CF_CAL_START_BIT = 7;
   localparam logic [7:0] BAND_SELECT_WR_MASK = 8'hE7;
   localparam logic [7:0] CF_CAL_RSVD_MASK = 8'h7F;

   // Band selector codes
   localparam logic [2:0] BAND_STD = 3'h0;
   localparam logic [2:0] BAND_ONE = 3'h1;
   localparam logic [2:0] BAND_TWO = 3'h2;
   localparam logic [2:0] BAND_THREE = 3'h3;
   localparam logic [2:0] BAND_FOUR = 3'h4;
   localparam logic [2:0] BAND_FIVE = 3'h5;
   localparam logic [2:0] BAND_SIX = 3'h6;

   // Highest alternative channel number per band
   localparam logic [7:0] BAND_FOUR_MAX_NUM = 8'h5E;
   localparam logic [7:0] BAND_FIVE_MAX_NUM = 8'h66;

   // Carrier figures in units of 100 kHz
   localparam logic [13:0] STEP_100KHZ = 14'h0001;
   localparam logic [13:0] STEP_1MHZ = 14'h000A;
   localparam logic [13:0] BAND_THREE_BASE = 14'h2346;
   localparam logic [13:0] BAND_FOUR_BASE = 14'h1E0A;
   localparam logic [13:0] BAND_FIVE_BASE = 14'h208A;
   localparam logic [13:0] BAND_SIX_BASE = 14'h233C;
   localparam logic [13:0] STD_CH0_FREQ = 14'h21EB;
   localparam logic [13:0] STD_CH1_FREQ = 14'h2364;
   localparam logic [13:0] STD_CH_STEP = 14'h0014;
   localparam logic [4:0] STD_CH_MAX = 5'h0A;

   // Calibration handshake states
   typedef enum logic [0:0]
   {
      CAL_IDLE = 1'b0,
      CAL_RUN = 1'b1
   } rfcbs_cal_type;

endpackage

// >>> rfcbs_freq_calc.sv
/*
   Carrier frequency calculator: maps band selector, alternative channel
   number and standard channel to a carrier in 100 kHz units.
   Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module rfcbs_freq_calc
#(
   parameter logic [13:0] BAND_ONE_BASE = 14'h0000,
   parameter logic [13:0] BAND_TWO_BASE = 14'h0000
)
(
   input wire logic [2:0] i_freq_band_select,
   input wire logic [7:0] i_alt_channel_number,
   input wire logic [4:0] i_std_channel,
   output logic [rfcbs_pkg::FREQ_W-1:0] o_carrier_freq,
   output logic o_carrier_valid
);
   import rfcbs_pkg::*;

   logic [13:0] alt_num;
   logic [13:0] std_ch;

   assign alt_num = {6'h00, i_alt_channel_number};
   assign std_ch = {9'h000, i_std_channel};

   // Base plus number times spacing per band
   always_comb
   begin
      o_carrier_freq = 14'h0000;
      o_carrier_valid = 1'b1;
      case (i_freq_band_select)
         BAND_STD:
         begin
            // Alternative number ignored here
            if (i_std_channel == 5'h00)
               o_carrier_freq = STD_CH0_FREQ;
            else
               o_carrier_freq = 14'(STD_CH1_FREQ + (std_ch - 14'h0001) * STD_CH_STEP);
            o_carrier_valid = (i_std_channel <= STD_CH_MAX);
         end
         BAND_ONE: o_carrier_freq = 14'(BAND_ONE_BASE + alt_num * STEP_100KHZ);
         BAND_TWO: o_carrier_freq = 14'(BAND_TWO_BASE + alt_num * STEP_100KHZ);
         BAND_THREE: o_carrier_freq = 14'(BAND_THREE_BASE + alt_num * STEP_100KHZ);
         BAND_FOUR:
         begin
            o_carrier_freq = 14'(BAND_FOUR_BASE + alt_num * STEP_1MHZ);
            o_carrier_valid = (i_alt_channel_number <= BAND_FOUR_MAX_NUM);
         end
         BAND_FIVE:
         begin
            o_carrier_freq = 14'(BAND_FIVE_BASE + alt_num * STEP_1MHZ);
            o_carrier_valid = (i_alt_channel_number <= BAND_FIVE_MAX_NUM);
         end
         BAND_SIX: o_carrier_freq = 14'(BAND_SIX_BASE + alt_num * STEP_100KHZ);
         default: o_carrier_valid = 1'b0; // Code 7 is reserved
      endcase
   end
endmodule

// >>> rfcbs_regs.sv
/*
   Channel and band select register group with the manual center
   frequency calibration start bit and its handshake to the synthesizer.
   Assumes a register port from the serial host engine on i_mclk and a
   calibration done level from the synthesizer, asynchronous to i_mclk.
   Reserved settings are flagged through the carrier valid output.
*/
// Contract
// - 8-bit read/write alternative channel number, reset zero, used only by alternative bands.
// - Band selector is 3 bits read/write at bits 2:0, reset zero.
// - Band zero uses standard channel field and ignores the alternative number.
// - Bands 1 to 6 give base plus number times spacing; 7 reserved.
// - Band register bits 7:3 reset zero; 4:3 read-only, 7:5 writable.
// - Calibration start at bit 7, reset zero; reserved bits 6:0 reset to 48h and take written data.
// - Writing one starts calibration; device clears bit when calibration completes.
// - Band four carrier is 769 MHz plus number times 1 MHz.
// - Standard channel field is written and read back at its register.
`timescale 1ns/100ps
module rfcbs_regs
#(
   parameter logic [13:0] BAND_ONE_BASE = 14'h0000,
   parameter logic [13:0] BAND_TWO_BASE = 14'h0000
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [rfcbs_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [rfcbs_pkg::DATA_W-1:0] i_reg_wdata,
   output logic [rfcbs_pkg::DATA_W-1:0] o_reg_rdata,
   input wire logic i_cf_cal_done,
   output logic o_cf_cal_start_pulse,
   output logic o_cf_cal_busy,
   output logic [2:0] o_freq_band_select,
   output logic [7:0] o_alt_channel_number,
   output logic [4:0] o_std_channel,
   output logic [rfcbs_pkg::FREQ_W-1:0] o_carrier_freq,
   output logic o_carrier_valid
);
   import rfcbs_pkg::*;

   // Bases must stay clear of the 14-bit carrier range with 255 steps added;
   // a larger base would wrap the carrier silently, so it is refused
   // while the design is elaborated, before any clock runs
   if (BAND_ONE_BASE > 14'h3F00 || BAND_TWO_BASE > 14'h3F00)
   begin : g_base_check
      $error("band base too high for carrier width");
   end

   // All state lives in one record so reset and next state stay in step.
   // The handshake state is kept apart from the start bit, so a write of
   // zero to bit 7 cannot end a running calibration early.
   typedef struct packed
   {
      logic [7:0] std_channel_cca;
      logic [7:0] alt_channel_number;
      logic [7:0] band_select;
      logic [7:0] cf_calibration_ctrl;
      rfcbs_cal_type cal_state;
      logic done_meta;
      logic done_sync;
      logic done_prev;
      logic start_pulse;
      logic [7:0] rdata;
      logic [13:0] carrier_freq;
      logic carrier_valid;
   } rfcbs_state_type;

   // Values after reset; the calibration register comes up with its
   // reserved pattern, the carrier with zero until the first edge
   localparam rfcbs_state_type RESET_STATE = '{
      std_channel_cca: STD_CHANNEL_CCA_RST,
      alt_channel_number: ALT_CHANNEL_NUMBER_RST,
      band_select: BAND_SELECT_RST,
      cf_calibration_ctrl: CF_CALIBRATION_CTRL_RST,
      cal_state: CAL_IDLE,
      done_meta: 1'b0,
      done_sync: 1'b0,
      done_prev: 1'b0,
      start_pulse: 1'b0,
      rdata: UNMAPPED_READ,
      carrier_freq: 14'h0000,
      carrier_valid: 1'b0
   };

   // State record and nets between the calculator and the record
   rfcbs_state_type cur_ff;
   rfcbs_state_type nxt_cur;
   logic [13:0] calc_freq;
   logic calc_valid;
   logic done_rise;
   logic start_req;

   // Address match, used by both write and read decode
   // Exact compare, so no place of the 6-bit space aliases another
   function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
      hit = (addr == off);
   endfunction

   // Carrier from the live register contents
   // The carrier is registered once more, so it trails a field write by
   // one cycle; in return the output never shows a half-decoded value
   rfcbs_freq_calc
   #(
      .BAND_ONE_BASE(BAND_ONE_BASE),
      .BAND_TWO_BASE(BAND_TWO_BASE)
   )
   u_freq_calc
   (
      .i_freq_band_select(cur_ff.band_select[BAND_SEL_MSB:0]),
      .i_alt_channel_number(cur_ff.alt_channel_number),
      .i_std_channel(cur_ff.std_channel_cca[STD_CHANNEL_MSB:0]),
      .o_carrier_freq(calc_freq),
      .o_carrier_valid(calc_valid)
   );

   // Edge of the synchronised done level; the metastable stage is not read
   // The previous-value stage resets low, the idle level of the done input
   assign done_rise = cur_ff.done_sync & ~cur_ff.done_prev;
   // A start needs bit 7 set; the other bits of the same write still land
   assign start_req = i_reg_wr & hit(i_reg_addr, CF_CALIBRATION_CTRL_OFF)
      & i_reg_wdata[CF_CAL_START_BIT];

   // Next state of the whole register group
   always_comb
   begin
      nxt_cur = cur_ff;
      // Two-stage synchroniser for the asynchronous done level
      nxt_cur.done_meta = i_cf_cal_done;
      nxt_cur.done_sync = cur_ff.done_meta;
      nxt_cur.done_prev = cur_ff.done_sync;
      nxt_cur.start_pulse = 1'b0;
      // Carrier registered for a clean output
      nxt_cur.carrier_freq = calc_freq;
      nxt_cur.carrier_valid = calc_valid;

      // Register writes; unmapped places match nothing and so change nothing
      // Reserved band bits 4:3 are masked on the way in
      if (i_reg_wr)
      begin
         if (hit(i_reg_addr, STD_CHANNEL_CCA_OFF))
            nxt_cur.std_channel_cca = i_reg_wdata;
         if (hit(i_reg_addr, ALT_CHANNEL_NUMBER_OFF))
            nxt_cur.alt_channel_number = i_reg_wdata;
         if (hit(i_reg_addr, BAND_SELECT_OFF))
            nxt_cur.band_select = i_reg_wdata & BAND_SELECT_WR_MASK;
         if (hit(i_reg_addr, CF_CALIBRATION_CTRL_OFF))
            nxt_cur.cf_calibration_ctrl[6:0] = i_reg_wdata[6:0] & CF_CAL_RSVD_MASK[6:0];
      end

      // Calibration handshake; writing zero cannot abort a running cycle
      case (cur_ff.cal_state)
         CAL_IDLE:
         begin
            // Done edges seen while idle are dropped
            if (start_req)
            begin
               nxt_cur.cf_calibration_ctrl[CF_CAL_START_BIT] = 1'b1;
               nxt_cur.start_pulse = 1'b1;
               nxt_cur.cal_state = CAL_RUN;
            end
         end
         CAL_RUN:
         begin
            // Only a fresh rise of done ends the cycle; a done level left
            // high by an earlier cycle cannot clear a new one
            if (done_rise)
            begin
               nxt_cur.cf_calibration_ctrl[CF_CAL_START_BIT] = 1'b0;
               nxt_cur.cal_state = CAL_IDLE;
            end
         end
         // An illegal code recovers to idle
         default: nxt_cur.cal_state = CAL_IDLE;
      endcase

      // Read data, registered; reserved band bits 4:3 come back zero
      // A read and a write in one cycle return the old contents; the data
      // then holds until the next read strobe
      if (i_reg_rd)
      begin
         if (hit(i_reg_addr, STD_CHANNEL_CCA_OFF))
            nxt_cur.rdata = cur_ff.std_channel_cca;
         else if (hit(i_reg_addr, ALT_CHANNEL_NUMBER_OFF))
            nxt_cur.rdata = cur_ff.alt_channel_number;
         else if (hit(i_reg_addr, BAND_SELECT_OFF))
            nxt_cur.rdata = cur_ff.band_select;
         else if (hit(i_reg_addr, CF_CALIBRATION_CTRL_OFF))
            nxt_cur.rdata = cur_ff.cf_calibration_ctrl;
         else
            nxt_cur.rdata = UNMAPPED_READ;
      end
   end

   // State register
   // Asynchronous reset loads the constant record only
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         cur_ff <= RESET_STATE;
      else
         cur_ff <= nxt_cur;
   end

   // Outputs straight from flip-flops
   // Busy is the start bit itself, so software and the synthesizer
   // always see the same level
   assign o_reg_rdata = cur_ff.rdata;
   assign o_cf_cal_start_pulse = cur_ff.start_pulse;
   assign o_cf_cal_busy = cur_ff.cf_calibration_ctrl[CF_CAL_START_BIT];
   assign o_freq_band_select = cur_ff.band_select[BAND_SEL_MSB:0];
   assign o_alt_channel_number = cur_ff.alt_channel_number;
   assign o_std_channel = cur_ff.std_channel_cca[STD_CHANNEL_MSB:0];
   assign o_carrier_freq = cur_ff.carrier_freq;
   assign o_carrier_valid = cur_ff.carrier_valid;
endmodule

// >>> rfcbs_regs_sva.sv
/*
   Checker for the channel and band register group.
   Assumes it is bound to rfcbs_regs and sees only its ports.
*/
`timescale 1ns/100ps
module rfcbs_regs_sva
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [5:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_cf_cal_done,
   input wire logic o_cf_cal_start_pulse,
   input wire logic o_cf_cal_busy,
   input wire logic [2:0] o_freq_band_select,
   input wire logic [7:0] o_alt_channel_number,
   input wire logic [4:0] o_std_channel,
   input wire logic [13:0] o_carrier_freq,
   input wire logic o_carrier_valid
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // Field writes land at the taking edge
   band_write_a: assert property (i_reg_wr && i_reg_addr == 6'h14
      |=> o_freq_band_select == $past(i_reg_wdata[2:0])) else $error("band select lost");
   alt_write_a: assert property (i_reg_wr && i_reg_addr == 6'h13
      |=> o_alt_channel_number == $past(i_reg_wdata)) else $error("alt number lost");
   rsvd_read_a: assert property (i_reg_rd && i_reg_addr == 6'h14
      |=> o_reg_rdata[4:3] == 2'h0) else $error("read-only bits not zero");
   // Calibration start is one pulse, never re-armed while busy
   cal_start_a: assert property (i_reg_wr && i_reg_addr == 6'h1A && i_reg_wdata[7]
      && !o_cf_cal_busy |=> o_cf_cal_start_pulse && o_cf_cal_busy) else $error("no start");
   cal_oneshot_a: assert property (o_cf_cal_busy |=> !o_cf_cal_start_pulse)
      else $error("extra start pulse");
   busy_clear_a: assert property ($rose(i_cf_cal_done) && o_cf_cal_busy
      |-> ##[1:4] !o_cf_cal_busy) else $error("busy not cleared");
   // Carrier trails the register outputs by one cycle
   band4_freq_a: assert property (o_freq_band_select == 3'h4 && o_alt_channel_number <= 8'h5E
      |=> o_carrier_freq == 14'h1E0A + 14'h000A * $past(o_alt_channel_number))
      else $error("band four carrier wrong");
   std_freq_a: assert property (o_freq_band_select == 3'h0 && o_std_channel == 5'h03
      |=> o_carrier_freq == 14'h238C) else $error("standard carrier wrong");
   band7_bad_a: assert property ((o_freq_band_select == 3'h7 || (o_freq_band_select == 3'h0
      && o_std_channel > 5'h0A)) |=> !o_carrier_valid) else $error("reserved setting valid");
   cover property (o_cf_cal_start_pulse);
   cover property (o_freq_band_select == 3'h4);
   cover property (o_freq_band_select == 3'h0 && !o_carrier_valid);
endmodule

bind rfcbs_regs rfcbs_regs_sva u_sva (.i_mclk, .i_nrst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
   .i_reg_wdata, .o_reg_rdata, .i_cf_cal_done, .o_cf_cal_start_pulse, .o_cf_cal_busy,
   .o_freq_band_select, .o_alt_channel_number, .o_std_channel, .o_carrier_freq,
   .o_carrier_valid);

// >>> rfcbs_synth_model.sv
/*
   Synthesizer stand-in for the calibration handshake.
   Assumes a one-cycle start pulse and a busy level from the block.
*/
`timescale 1ns/100ps
module rfcbs_synth_model
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_cal_start,
   input wire logic i_cal_busy,
   input wire logic [7:0] i_delay,
   output logic o_cal_done
);
   logic [7:0] cnt_ff;
   // Loop settles after i_delay steps; done held until busy drops
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_ff <= 8'h00;
         o_cal_done <= 1'b0;
      end
      else
      begin
         cnt_ff <= i_cal_start ? i_delay : cnt_ff - {7'h00, cnt_ff != 8'h00};
         o_cal_done <= (cnt_ff == 8'h01) | (o_cal_done & i_cal_busy);
      end
   end
endmodule

// >>> rfcbs_regs_tb.sv
/*
   Self-checking bench for rfcbs_regs.
   Assumes the synthesizer model answers calibration starts.
*/
`timescale 1ns/100ps
module rfcbs_regs_tb;
   logic i_mclk, i_nrst, i_reg_wr, i_reg_rd, done, pulse, busy, valid, pend;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, alt, num, delay;
   logic [2:0] band;
   logic [4:0] stdch;
   logic [13:0] carrier;
   logic [7:0] exp_q[$];
   int fails = 0;
   int num_checks = 0;
   int n;
   rfcbs_regs uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_cf_cal_done(done),
      .o_cf_cal_start_pulse(pulse), .o_cf_cal_busy(busy), .o_freq_band_select(band),
      .o_alt_channel_number(alt), .o_std_channel(stdch), .o_carrier_freq(carrier),
      .o_carrier_valid(valid));
   rfcbs_synth_model synth (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cal_start(pulse),
      .i_cal_busy(busy), .i_delay(delay), .o_cal_done(done));
   // Clock
   initial
   begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   // One strobe per access, driven just after the edge
   task acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #2;
      addr = a;
      wdata = d;
      i_reg_wr = wr;
      i_reg_rd = !wr;
      @(posedge i_mclk);
      #2;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'($urandom));
   endtask
   // Read data appears after the taking edge; pair it with the oldest note
   always @(posedge i_mclk)
   begin
      pend = i_reg_rd;
      #1;
      if (pend)
         chk("rdata", exp_q.pop_front(), rdata);
   end
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, far beyond the roughly 150 cycles the run needs
   initial
   begin
      #100000;
      fails++;
      close_out;
   end
   initial
   begin
      {i_nrst, i_reg_wr, i_reg_rd, addr, wdata, delay} = '0;
      void'($urandom(32'hF1E3));
      repeat (8) @(posedge i_mclk);
      #2;
      i_nrst = 1'b1;
      rd(6'h08, 8'h00);
      rd(6'h13, 8'h00);
      rd(6'h14, 8'h00);
      rd(6'h1A, 8'h48);
      rd(6'h2A, 8'h00); // Unmapped place reads zero
      // Bits 7:5 take a write, 4:3 stay zero; band six with number zero is legal
      acc(1'b1, 6'h14, 8'hFE);
      rd(6'h14, 8'hE6);
      // Each alternative band; number parked at zero across the band change
      for (n = 1; n < 7; n++)
      begin
         num = 8'($urandom % (n == 4 ? 9'h05F : n == 5 ? 9'h067 : 9'h100));
         acc(1'b1, 6'h13, 8'h00);
         acc(1'b1, 6'h14, 8'hE0 | n[7:0]);
         acc(1'b1, 6'h13, num);
         rd(6'h13, num);
         rd(6'h14, 8'hE0 | n[7:0]);
         chk("band", n[2:0], band);
         chk("alt", num, alt);
         if (n == 4)
            chk("carrier", 14'h1E0A + 14'h000A * num, carrier);
      end
      // Band zero uses the standard channel; a reserved channel is flagged
      acc(1'b1, 6'h14, 8'hE0);
      acc(1'b1, 6'h08, 8'h03);
      rd(6'h08, 8'h03);
      chk("stdch", 14'h0003, stdch);
      chk("carrier", 14'h238C, carrier);
      chk("valid", 14'h0001, valid);
      acc(1'b1, 6'h08, 8'h0B);
      @(posedge i_mclk);
      #2;
      chk("valid", 14'h0000, valid);
      // Calibration with a prompt and then a slow loop
      for (n = 0; n < 2; n++)
      begin
         delay = n ? 8'h28 : 8'h02;
         acc(1'b1, 6'h1A, 8'hC8);
         rd(6'h1A, 8'hC8);
         for (int k = 0; k < 100 && busy !== 1'b0; k++)
         begin
            @(posedge i_mclk);
            #2;
         end
         chk("busy", 14'h0000, busy);
         rd(6'h1A, 8'h48);
      end
      close_out;
   end
endmodule
